//--- core/fw_loader.sv
// Firmware update and calibration coefficient register block
//
// Behaviour
// - Control bit 7 arms firmware update
// - Control bit 6 write resets update machine
// - Control bit 5 shows whole image received
// - Control bit 4 locks firmware for restart
// - Control bit 3 write switches active image
// - Control bit 2 high while bank one
// - Control bit 1 flags update error
// - Control bit 0 other bank checksum valid
// - Sixteen bit byte count, high first, resets zero
// - Payload write delivers one image byte
// - Result source select plus slave presence flags
// - Four byte coefficient data window, read/write
// - Read index write loads window from table
// - Write index write stores window to table
// - Update control bit 7 starts update
// - Update control bit 6 aborts update
// - Update bit 5 set after full image
// - Toggle checks image, else only the error flag changes
// - Next expected byte address, high then low
// - Download register takes next image byte
`timescale 1ns/1ps
`include "fw_loader_consts.svh"

module fw_loader
  import fw_loader_pkg::*;
#(
  parameter int IMAGE_BYTES  = `IMAGE_BYTES_DEF,
  parameter int COEF_ENTRIES = 256
) (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  // Register port from the host interface
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // Slave presence pins
  input  wire logic       FIRST_SLAVE_PIN,
  input  wire logic       SECOND_SLAVE_PIN,
  // Flash and system side
  output flash_wr_t       FLASH_WR,
  output logic            FIRST_BANK_ACTIVE,
  output logic            IMAGE_LOCK,
  output logic            REBOOT,
  output logic      [1:0] RESULT_SOURCE_SELECT
);

  // ----------------------------------------
  // Reset release and pin filters
  // ----------------------------------------
  logic       rst_meta_r;
  logic       rst_b_r;
  logic [2:0] first_sync_r;
  logic [2:0] second_sync_r;
  logic       first_present_r;
  logic       second_present_r;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_r <= 1'b0;
      rst_b_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b_r    <= rst_meta_r;
    end
  end

  // Third stage only compared against second, never the first
  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      first_sync_r     <= 3'h0;
      second_sync_r    <= 3'h0;
      first_present_r  <= 1'b0;
      second_present_r <= 1'b0;
    end else begin
      first_sync_r  <= {first_sync_r[1:0], FIRST_SLAVE_PIN};
      second_sync_r <= {second_sync_r[1:0], SECOND_SLAVE_PIN};
      if (first_sync_r[1] == first_sync_r[2]) begin
        first_present_r <= first_sync_r[2];
      end
      if (second_sync_r[1] == second_sync_r[2]) begin
        second_present_r <= second_sync_r[2];
      end
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Upper update window 0xe0..0xe3 mirrors 0x60..0x63
  function automatic logic [7:0] fold(input logic [7:0] a);
    if (a[7:2] == `ALIAS_BASE_HI) begin
      fold = a & `ALIAS_CLEAR_MASK;
    end else begin
      fold = a;
    end
  endfunction

  logic [7:0] wa;
  logic       ctrl_wr;
  logic       byte_wr;
  logic       begin_ev;
  logic       abort_ev;
  logic       switch_ev;

  assign wa        = fold(REG_ADDR);
  assign ctrl_wr   = REG_WR && (wa == `OFS_FIRMWARE_CONTROL || wa == `OFS_UPDATE_CTRL);
  assign byte_wr   = REG_WR && (wa == `OFS_PAYLOAD || wa == `OFS_DOWNLOAD);
  assign begin_ev  = ctrl_wr && REG_WDATA[`BIT_BEGIN];
  assign abort_ev  = ctrl_wr && REG_WDATA[`BIT_ABORT];
  assign switch_ev = ctrl_wr && REG_WDATA[`BIT_SWITCH];

  // ----------------------------------------
  // Update state machine
  // ----------------------------------------
  load_state_t state_r;
  logic [15:0] count_r;
  logic [7:0]  sum_r;
  logic [7:0]  payload_r;
  logic        error_r;
  logic        full;
  logic        image_ok;
  logic        accept;
  logic        switch_ok;

  assign full      = (state_r == ST_FULL);
  assign image_ok  = full && (sum_r == `SUM_GOOD);
  assign accept    = byte_wr && (state_r == ST_LOAD) && !abort_ev;
  assign switch_ok = switch_ev && image_ok && !abort_ev;

  // Abort beats a start written in the same byte
  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (begin_ev && !abort_ev) begin
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (abort_ev) begin
            state_r <= ST_IDLE;
          end else if (accept && count_r == 16'(IMAGE_BYTES - 1)) begin
            state_r <= ST_FULL;
          end
        end
        ST_FULL: begin
          if (abort_ev || switch_ok) begin
            state_r <= ST_IDLE;
          end else if (begin_ev) begin
            state_r <= ST_LOAD;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Count doubles as next expected address; held once the image is whole
  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      count_r <= `COUNT_ZERO;
      sum_r   <= `SUM_GOOD;
    end else if (abort_ev || (begin_ev && state_r != ST_LOAD)) begin
      count_r <= `COUNT_ZERO;
      sum_r   <= `SUM_GOOD;
    end else if (accept) begin
      count_r <= count_r + `COUNT_ONE;
      sum_r   <= sum_r + REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      payload_r <= `BYTE_ZERO;
    end else if (byte_wr) begin
      payload_r <= REG_WDATA;
    end
  end

  // Stray byte or failed switch sets the flag; set wins over a clear
  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      error_r <= 1'b0;
    end else if ((byte_wr && state_r != ST_LOAD) || (switch_ev && !switch_ok)) begin
      error_r <= 1'b1;
    end else if (begin_ev || abort_ev) begin
      error_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Bank, lock and flash writes
  // ----------------------------------------
  logic      bank_r;
  logic      lock_r;
  logic      toggle_r;
  logic      reboot_r;
  flash_wr_t flash_r;

  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      bank_r   <= `BANK_FIRST;
      toggle_r <= 1'b0;
      reboot_r <= 1'b0;
    end else begin
      reboot_r <= switch_ok;
      if (switch_ok) begin
        bank_r   <= ~bank_r;
        toggle_r <= ~toggle_r;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      lock_r <= 1'b0;
    end else if (REG_WR && wa == `OFS_FIRMWARE_CONTROL) begin
      lock_r <= REG_WDATA[`BIT_LOCK];
    end
  end

  // Image always lands in the bank that is not running
  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      flash_r <= '0;
    end else begin
      flash_r.valid <= accept;
      if (accept) begin
        flash_r.bank <= ~bank_r;
        flash_r.addr <= count_r;
        flash_r.data <= REG_WDATA;
      end
    end
  end

  // ----------------------------------------
  // Source select and coefficients
  // ----------------------------------------
  logic [1:0]  sel_r;
  logic [31:0] window_r;
  logic [7:0]  rd_index_r;
  logic [7:0]  wr_index_r;
  logic [31:0] coef_mem [COEF_ENTRIES];

  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      sel_r <= `SEL_RESET;
    end else if (REG_WR && wa == `OFS_SOURCE_SELECT) begin
      sel_r <= REG_WDATA[1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      window_r   <= `WORD_ZERO;
      rd_index_r <= `BYTE_ZERO;
      wr_index_r <= `BYTE_ZERO;
    end else if (REG_WR) begin
      case (wa)
        `OFS_COEF_BYTE0: window_r[7:0]   <= REG_WDATA;
        `OFS_COEF_BYTE1: window_r[15:8]  <= REG_WDATA;
        `OFS_COEF_BYTE2: window_r[23:16] <= REG_WDATA;
        `OFS_COEF_BYTE3: window_r[31:24] <= REG_WDATA;
        `OFS_COEFFICIENT_READ_INDEX: begin
          rd_index_r <= REG_WDATA;
          window_r   <= coef_mem[REG_WDATA];
        end
        `OFS_COEFFICIENT_WRITE_INDEX: wr_index_r <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Table has no reset; it stands for persistent storage
  always_ff @(posedge SYS_CLK) begin
    if (REG_WR && wa == `OFS_COEFFICIENT_WRITE_INDEX) begin
      coef_mem[REG_WDATA] <= window_r;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] ctrl_view;
  logic [7:0] upd_view;
  logic [7:0] rd_nxt;

  always_comb begin
    ctrl_view              = `BYTE_ZERO;
    ctrl_view[`BIT_BEGIN]  = (state_r != ST_IDLE);
    ctrl_view[`BIT_FULL]   = full;
    ctrl_view[`BIT_LOCK]   = lock_r;
    ctrl_view[`BIT_BANK]   = bank_r;
    ctrl_view[`BIT_ERROR]  = error_r;
    ctrl_view[`BIT_VALID]  = image_ok;
    upd_view               = `BYTE_ZERO;
    upd_view[`BIT_BEGIN]   = (state_r != ST_IDLE);
    upd_view[`BIT_FULL]    = full;
    upd_view[`BIT_SWITCH]  = toggle_r;
  end

  always_comb begin
    case (wa)
      `OFS_FIRMWARE_CONTROL:    rd_nxt = ctrl_view;
      `OFS_COUNT_HIGH:    rd_nxt = count_r[15:8];
      `OFS_COUNT_LOW:     rd_nxt = count_r[7:0];
      `OFS_PAYLOAD:       rd_nxt = payload_r;
      `OFS_SOURCE_SELECT: rd_nxt = {2'h0, second_present_r, first_present_r, 2'h0, sel_r};
      `OFS_COEF_BYTE0:    rd_nxt = window_r[7:0];
      `OFS_COEF_BYTE1:    rd_nxt = window_r[15:8];
      `OFS_COEF_BYTE2:    rd_nxt = window_r[23:16];
      `OFS_COEF_BYTE3:    rd_nxt = window_r[31:24];
      `OFS_COEFFICIENT_READ_INDEX:     rd_nxt = rd_index_r;
      `OFS_COEFFICIENT_WRITE_INDEX:    rd_nxt = wr_index_r;
      `OFS_UPDATE_CTRL:   rd_nxt = upd_view;
      `OFS_NEXT_HIGH:     rd_nxt = count_r[15:8];
      `OFS_NEXT_LOW:      rd_nxt = count_r[7:0];
      `OFS_DOWNLOAD:      rd_nxt = payload_r;
      default:            rd_nxt = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      REG_RDATA <= `BYTE_ZERO;
    end else if (REG_RD) begin
      REG_RDATA <= rd_nxt;
    end
  end

  assign FLASH_WR             = flash_r;
  assign FIRST_BANK_ACTIVE    = bank_r;
  assign IMAGE_LOCK           = lock_r;
  assign REBOOT               = reboot_r;
  assign RESULT_SOURCE_SELECT = sel_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!rst_b_r);
  property p_begin_arms;
    (begin_ev && !abort_ev && state_r == ST_IDLE) |=> (state_r == ST_LOAD);
  endproperty
  a_begin_arms: assert property (p_begin_arms) else $error("start did not arm");
  property p_abort_idles;
    abort_ev |=> (state_r == ST_IDLE && count_r == `COUNT_ZERO);
  endproperty
  a_abort_idles: assert property (p_abort_idles) else $error("abort left state");
  property p_full_at_end;
    (accept && count_r == 16'(IMAGE_BYTES - 1)) |=> full;
  endproperty
  a_full_at_end: assert property (p_full_at_end) else $error("full flag missing");
  property p_count_step;
    accept |=> (count_r == $past(count_r) + `COUNT_ONE);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count not stepped");
  property p_count_held_full;
    (full && byte_wr && !abort_ev && !begin_ev) |=> $stable(count_r) && error_r;
  endproperty
  a_count_held_full: assert property (p_count_held_full) else $error("count moved");
  property p_switch_flips;
    switch_ok |=> (bank_r != $past(bank_r)) && REBOOT ##1 !REBOOT;
  endproperty
  a_switch_flips: assert property (p_switch_flips) else $error("bank not switched");
  property p_bad_switch_keeps;
    (switch_ev && !image_ok) |=> $stable(bank_r) && $stable(toggle_r) && error_r;
  endproperty
  a_bad_switch_keeps: assert property (p_bad_switch_keeps) else $error("bad switch");
  property p_flash_follows;
    accept |=> FLASH_WR.valid && FLASH_WR.data == $past(REG_WDATA) && FLASH_WR.bank != bank_r;
  endproperty
  a_flash_follows: assert property (p_flash_follows) else $error("byte not sent");
  property p_coef_store;
    (REG_WR && wa == `OFS_COEFFICIENT_WRITE_INDEX) ##1 (REG_WR && wa == `OFS_COEFFICIENT_READ_INDEX
      && REG_WDATA == $past(REG_WDATA)) |=> window_r == $past(window_r, 2);
  endproperty
  a_coef_store: assert property (p_coef_store) else $error("coef lost");

  c_full_image:  cover property (full);
  c_good_switch: cover property (switch_ok);
  c_abort_load:  cover property (state_r == ST_LOAD ##1 abort_ev);

endmodule

//--- core/fw_loader_consts.svh
// Offsets, field positions, reset values and sizes of the loader registers
`ifndef FW_LOADER_CONSTS_SVH
`define FW_LOADER_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_FIRMWARE_CONTROL     8'h48
`define OFS_COUNT_HIGH     8'h49
`define OFS_COUNT_LOW      8'h4a
`define OFS_PAYLOAD        8'h4b
`define OFS_SOURCE_SELECT  8'h4f
`define OFS_COEF_BYTE0     8'h50
`define OFS_COEF_BYTE1     8'h51
`define OFS_COEF_BYTE2     8'h52
`define OFS_COEF_BYTE3     8'h53
`define OFS_COEFFICIENT_READ_INDEX      8'h54
`define OFS_COEFFICIENT_WRITE_INDEX     8'h55
`define OFS_UPDATE_CTRL    8'h60
`define OFS_NEXT_HIGH      8'h61
`define OFS_NEXT_LOW       8'h62
`define OFS_DOWNLOAD       8'h63
`define ALIAS_BASE_HI      6'h38
`define ALIAS_CLEAR_MASK   8'h7f

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define BIT_BEGIN          7
`define BIT_ABORT          6
`define BIT_FULL           5
`define BIT_LOCK           4
`define BIT_SWITCH         3
`define BIT_BANK           2
`define BIT_ERROR          1
`define BIT_VALID          0
`define BIT_SECOND_SLAVE   5
`define BIT_FIRST_SLAVE    4

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define IMAGE_BYTES_DEF    57344
`define COUNT_ZERO         16'h0000
`define COUNT_ONE          16'h0001
`define BYTE_ZERO          8'h00
`define WORD_ZERO          32'h0000_0000
`define SEL_RESET          2'h0
`define SUM_GOOD           8'h00
`define BANK_FIRST         1'b1

`endif

//--- core/fw_loader_pkg.sv
// Types shared by the firmware loader
package fw_loader_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_FULL = 2'b10
  } load_state_t;

  typedef struct packed {
    logic        valid;
    logic        bank;
    logic [15:0] addr;
    logic [7:0]  data;
  } flash_wr_t;

endpackage

//--- dv/flash_model.sv
// Flash side model that absorbs the image bytes from the loader
`timescale 1ns/1ps

module flash_model
  import fw_loader_pkg::*;
#(
  parameter int IMAGE_BYTES = 8
) (
  // ----------------------------------------
  // Clock
  // ----------------------------------------
  input wire logic      SYS_CLK,
  // ----------------------------------------
  // Write stream from the loader
  // ----------------------------------------
  input wire flash_wr_t FLASH_WR
);
  logic [7:0] mem_r [2][IMAGE_BYTES];
  int         writes;

  initial writes = 0;

  // Stores at once; a real part would need an erase first
  always @(posedge SYS_CLK) begin
    if (FLASH_WR.valid === 1'b1) begin
      mem_r[FLASH_WR.bank][FLASH_WR.addr % IMAGE_BYTES] <= FLASH_WR.data;
      writes <= writes + 1;
    end
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the firmware loader register block
`timescale 1ns/1ps
`include "fw_loader_consts.svh"

module testbench
  import fw_loader_pkg::*;
;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  localparam int NB = 8;
  localparam logic [7:0] RST_A [9] = '{8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4f, 8'h61, 8'h62,
                                       8'h50, 8'h40};
  localparam logic [7:0] RST_V [9] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00,
                                       8'h00, 8'h00};
  localparam logic [7:0] AB_A [2]  = '{8'h48, 8'h60};
  logic        SYS_CLK;
  logic        RST_B;
  logic        REG_WR;
  logic        REG_RD;
  logic [7:0]  REG_ADDR;
  logic [7:0]  REG_WDATA;
  logic [7:0]  REG_RDATA;
  logic        FIRST_SLAVE_PIN;
  logic        SECOND_SLAVE_PIN;
  flash_wr_t   FLASH_WR;
  logic        FIRST_BANK_ACTIVE;
  logic        IMAGE_LOCK;
  logic        REBOOT;
  logic [1:0]  RESULT_SOURCE_SELECT;
  int          miscompares;
  int          total_checks;
  int          reboots;
  logic [31:0] seed;
  logic        fa;
  logic [31:0] w;
  logic [7:0]  idx;
  string       rd_name [$];
  logic [7:0]  rd_exp  [$];
  logic [7:0]  rd_mask [$];
  flash_wr_t   fl_exp  [$];
  logic [7:0]  img     [2][NB];

  fw_loader #(.IMAGE_BYTES(NB), .COEF_ENTRIES(256)) DUT (
    .SYS_CLK              (SYS_CLK),
    .RST_B                (RST_B),
    .REG_WR               (REG_WR),
    .REG_RD               (REG_RD),
    .REG_ADDR             (REG_ADDR),
    .REG_WDATA            (REG_WDATA),
    .REG_RDATA            (REG_RDATA),
    .FIRST_SLAVE_PIN      (FIRST_SLAVE_PIN),
    .SECOND_SLAVE_PIN     (SECOND_SLAVE_PIN),
    .FLASH_WR             (FLASH_WR),
    .FIRST_BANK_ACTIVE    (FIRST_BANK_ACTIVE),
    .IMAGE_LOCK           (IMAGE_LOCK),
    .REBOOT               (REBOOT),
    .RESULT_SOURCE_SELECT (RESULT_SOURCE_SELECT)
  );

  flash_model #(.IMAGE_BYTES(NB)) flash (
    .SYS_CLK  (SYS_CLK),
    .FLASH_WR (FLASH_WR)
  );

  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strobe drops a full cycle later, so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge SYS_CLK);
    REG_WR    = 1'b1;
    REG_ADDR  = a;
    REG_WDATA = d;
    @(negedge SYS_CLK);
    REG_WR    = 1'b0;
  endtask

  // Two writes on consecutive edges, same data, strobe held between them
  task automatic wr2(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] d);
    @(negedge SYS_CLK);
    REG_WR    = 1'b1;
    REG_ADDR  = a0;
    REG_WDATA = d;
    @(negedge SYS_CLK);
    REG_ADDR  = a1;
    @(negedge SYS_CLK);
    REG_WR    = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rd_name.push_back($sformatf("reg %h", a));
    rd_exp.push_back(e);
    rd_mask.push_back(m);
    @(negedge SYS_CLK);
    REG_RD   = 1'b1;
    REG_ADDR = a;
    @(negedge SYS_CLK);
    REG_RD   = 1'b0;
  endtask

  // Sum of all bytes is zero for a good image, one for a bad one
  task automatic load(input logic good);
    logic [7:0] d;
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < NB; i++) begin
      d = (i == NB - 1) ? (8'h00 - sum + {7'h0, ~good}) : rnd();
      sum = sum + d;
      fl_exp.push_back('{1'b1, ~fa, i[15:0], d});
      img[~fa][i] = d;
      wr((i % 3 == 1) ? `OFS_PAYLOAD : ((i % 3 == 2) ? 8'he3 : `OFS_DOWNLOAD), d);
      if (i == 2) begin
        rd(`OFS_NEXT_HIGH, 8'h00, 8'hff);
        rd(`OFS_NEXT_LOW, 8'h03, 8'hff);
        rd(`OFS_COUNT_LOW, 8'h03, 8'hff);
      end
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(posedge SYS_CLK) begin
    if (REG_RD === 1'b1) begin
      @(negedge SYS_CLK);
      if (rd_exp.size() == 0) check("read note", 32'h1, 32'h0);
      else check(rd_name.pop_front(), {24'h0, REG_RDATA & rd_mask.pop_front()},
                 {24'h0, rd_exp.pop_front()});
    end
  end

  // An unexpected flash write finds no note and counts as a mismatch
  always @(negedge SYS_CLK) begin
    if (FLASH_WR.valid === 1'b1) begin
      if (fl_exp.size() == 0) check("flash note", 32'h1, 32'h0);
      else check("flash write", {6'h0, FLASH_WR}, {6'h0, fl_exp.pop_front()});
    end
    if (REBOOT === 1'b1) reboots++;
  end

  initial begin
    #(20000 * 4);
    miscompares++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h6de3;
    fa = 1'b1;
    miscompares = 0;
    total_checks = 0;
    reboots = 0;
    RST_B = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    FIRST_SLAVE_PIN = 1'b1;
    SECOND_SLAVE_PIN = 1'b0;
    repeat (3) @(negedge SYS_CLK);
    RST_B = 1'b1;
    repeat (4) @(negedge SYS_CLK);
    foreach (RST_A[k]) rd(RST_A[k], RST_V[k], 8'hff);
    rd(`OFS_UPDATE_CTRL, 8'h00, 8'he8);
    check("bank", FIRST_BANK_ACTIVE, 1'b1);
    wr(`OFS_DOWNLOAD, 8'h5a);
    rd(`OFS_FIRMWARE_CONTROL, 8'h02, 8'h02);
    rd(`OFS_PAYLOAD, 8'h5a, 8'hff);
    wr(8'he0, 8'h80);
    rd(`OFS_FIRMWARE_CONTROL, 8'h84, 8'hff);
    load(1'b1);
    rd(`OFS_FIRMWARE_CONTROL, 8'ha5, 8'hff);
    wr(`OFS_DOWNLOAD, rnd());
    rd(`OFS_UPDATE_CTRL, 8'ha0, 8'he8);
    rd(`OFS_NEXT_LOW, 8'h08, 8'hff);
    wr(`OFS_FIRMWARE_CONTROL, 8'h08);
    fa = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    check("reboots", reboots, 1);
    check("bank", FIRST_BANK_ACTIVE, 1'b0);
    rd(`OFS_UPDATE_CTRL, 8'h08, 8'h08);
    rd(`OFS_FIRMWARE_CONTROL, 8'h00, 8'h94);
    wr(`OFS_FIRMWARE_CONTROL, 8'h80);
    load(1'b0);
    rd(`OFS_FIRMWARE_CONTROL, 8'ha0, 8'ha7);
    wr(`OFS_UPDATE_CTRL, 8'h08);
    repeat (2) @(negedge SYS_CLK);
    check("reboots", reboots, 1);
    check("bank", FIRST_BANK_ACTIVE, 1'b0);
    rd(`OFS_FIRMWARE_CONTROL, 8'h02, 8'h07);
    rd(`OFS_UPDATE_CTRL, 8'h08, 8'h08);
    foreach (AB_A[k]) begin
      wr(`OFS_FIRMWARE_CONTROL, 8'h80);
      wr(AB_A[k], 8'h40);
      rd(`OFS_FIRMWARE_CONTROL, 8'h00, 8'hc2);
      wr(`OFS_DOWNLOAD, rnd());
      rd(`OFS_FIRMWARE_CONTROL, 8'h02, 8'h02);
    end
    wr(`OFS_FIRMWARE_CONTROL, 8'h10);
    check("lock", IMAGE_LOCK, 1'b1);
    rd(`OFS_FIRMWARE_CONTROL, 8'h10, 8'h10);
    for (int s = 0; s < 3; s++) begin
      SECOND_SLAVE_PIN = s[0];
      repeat (5) @(negedge SYS_CLK);
      wr(`OFS_SOURCE_SELECT, s[7:0]);
      check("select", RESULT_SOURCE_SELECT, s[1:0]);
      rd(`OFS_SOURCE_SELECT, {2'h0, s[0], 5'h10} | s[7:0], 8'h33);
    end
    idx = rnd();
    for (int k = 0; k < 2; k++) begin
      w = {rnd(), rnd(), rnd(), rnd()};
      for (int b = 0; b < 4; b++) wr(`OFS_COEF_BYTE0 + b[7:0], w[8*b +: 8]);
      wr(`OFS_COEFFICIENT_WRITE_INDEX, idx ^ k[7:0]);
      for (int b = 0; b < 4; b++) wr(`OFS_COEF_BYTE0 + b[7:0], ~w[8*b +: 8]);
      rd(`OFS_COEF_BYTE3, ~w[31:24], 8'hff);
      wr(`OFS_COEFFICIENT_READ_INDEX, idx ^ k[7:0]);
      for (int b = 0; b < 4; b++) rd(`OFS_COEF_BYTE0 + b[7:0], w[8*b +: 8], 8'hff);
    end
    wr2(`OFS_COEFFICIENT_WRITE_INDEX, `OFS_COEFFICIENT_READ_INDEX, idx);
    rd(`OFS_COEF_BYTE0, w[7:0], 8'hff);
    rd(`OFS_COEFFICIENT_READ_INDEX, idx, 8'hff);
    repeat (4) @(negedge SYS_CLK);
    check("pending notes", rd_exp.size() + fl_exp.size(), 0);
    check("flash writes", flash.writes, 2 * NB);
    foreach (img[b, i]) check("flash data", flash.mem_r[b][i], img[b][i]);
    summarize();
  end
endmodule
